// ==== rtl/touch_key_proximity_ctrl.v ====
// Notes on behaviour
// - auto-start-delay enable set inserts the start delay before each sequence
// - pseudo-random enable randomises charge/discharge timing, else fixed
// - noise flag sets on low-frequency noise; software clears by writing zero
// - writing one to start launches a sequence; hardware clears it when done
// - busy reads one at the start bit position while a sequence runs
// - 4-bit clock select picks system clock divisors or slow oscillator undivided or /2
// - each pull selection bit enables one weighted current or resistor source
// - proximity excitation runs on the engine clock, sets its frequency
// - seven receive calibration bits each switch in a weighted capacitor
// - pseudo-load bits take effect only while proximity enable is one
// - settling lasts four engine periods times settling field plus one
// - start delay is 256 engine periods times delay field plus one
// - threshold is raw value, or value plus baseline when mode select is one
// - filter ignores steady comparator longer than eight times setting
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "touch_key_consts.vh"
module touch_key_proximity_ctrl #(
	parameter CONV_LEN = 1024
) (
	// clock, reset, enable
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        clk_en,
	// axi4-lite write
	input  wire [17:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read
	input  wire [17:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// analog front end
	input  wire        comparator_in,
	input  wire        slow_high_oscillator,
	output reg         charge_phase,
	output reg         proximity_transmit_out,
	output reg  [6:0]  receive_cancel_cal,
	output reg  [3:0]  pseudo_load_select,
	output reg  [3:0]  pull_current_select,
	output reg  [3:0]  pull_resistor_select,
	output reg  [2:0]  charge_cap_select,
	output reg         irq
);
	localparam ST_IDLE = 3'd0;
	localparam ST_DELAY = 3'd1;
	localparam ST_SETTLE = 3'd2;
	localparam ST_CONV = 3'd3;
	localparam ST_DONE = 3'd4;

	////////////////////////////////////////////////////////////////////////
	// registers
	reg [7:0]  prox_cfg_enable_receive_cancel_cal;
	reg [7:0]  prox_cfg_cref_gain;
	reg [7:0]  prox_cfg_amp_power;
	reg [7:0]  prox_cfg_load;
	reg [7:0]  touch_clock_select;
	reg [7:0]  touch_ctrl_status;
	reg [7:0]  engine_cfg;
	reg [7:0]  touch_pullup_ctrl;
	reg [15:0] high_duty;
	reg [15:0] low_duty;
	reg [15:0] slow_baseline;
	reg [15:0] detect_threshold;
	reg [1:0]  irq_status;
	reg [1:0]  irq_mask;
	// engine
	reg [2:0]  state;
	reg [7:0]  div_cnt;
	reg        engine_tick;
	reg [9:0]  unit_cnt;
	reg [1:0]  mult_cnt;
	reg [15:0] conv_cnt;
	reg [15:0] lfsr;
	reg [4:0]  steady_cnt;
	reg        comp_prev;
	reg        cmp_s1;
	reg        cmp_s2;
	reg        osc_s1;
	reg        osc_s2;
	reg        osc_prev;
	reg        osc_half;
	reg        seq_done;
	reg        thresh_hit;
	reg        noise_seen;
	// bus handshake latches
	reg        aw_held;
	reg        w_held;
	reg [17:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers for pins
	always @(posedge aclk) begin
		if (!aresetn) begin
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
		end else if (clk_en) begin
			cmp_s1 <= comparator_in;
			cmp_s2 <= cmp_s1;
			osc_s1 <= slow_high_oscillator;
			osc_s2 <= osc_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// engine clock tick generator
	reg [7:0] div_limit;
	reg       use_osc;
	reg       osc_by4;
	always @* begin
		div_limit = 8'h00;
		use_osc = 1'b0;
		osc_by4 = 1'b0;
		case (touch_clock_select[3:0])
		4'h0: div_limit = 8'h01;
		4'h1: div_limit = 8'h03;
		4'h2: div_limit = 8'h05;
		4'h3: div_limit = 8'h09;
		4'h4: div_limit = 8'h0f;
		4'h5: div_limit = 8'h1f;
		4'h6: div_limit = 8'hff;
		4'he: use_osc = 1'b1;
		4'hf: begin
			use_osc = 1'b1;
			osc_by4 = 1'b1;
		end
		default: div_limit = 8'hff;
		endcase
	end

	// one tick per engine period; the tick also toggles the excitation
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 8'h00;
			engine_tick <= 1'b0;
			osc_prev <= 1'b0;
			osc_half <= 1'b0;
		end else if (clk_en) begin
			osc_prev <= osc_s2;
			engine_tick <= 1'b0;
			if (use_osc) begin
				if (osc_s2 && !osc_prev) begin
					osc_half <= ~osc_half;
					if (!osc_by4 || osc_half)
						engine_tick <= 1'b1;
				end
			end else if (div_cnt >= div_limit) begin
				div_cnt <= 8'h00;
				engine_tick <= 1'b1;
			end else begin
				div_cnt <= div_cnt + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion sequencer
	wire        start_req = touch_ctrl_status[`BIT_START_BUSY];
	wire        auto_mode = engine_cfg[`BIT_AUTO_MODE];
	wire [1:0]  settle_f = engine_cfg[`POS_SETTLE+1:`POS_SETTLE];
	wire [1:0]  delay_f = engine_cfg[`POS_START_DELAY+1:`POS_START_DELAY];
	wire [1:0]  filt_f = engine_cfg[`POS_NOISE_FILT+1:`POS_NOISE_FILT];
	wire [16:0] eff_thresh = engine_cfg[`BIT_THRESH_MODE] ?
		({1'b0, detect_threshold} + {1'b0, slow_baseline}) :
		{1'b0, detect_threshold};
	wire [4:0]  filt_limit = {filt_f, 3'b000};
	wire        filt_on = (filt_f != 2'b00);
	wire        comp_ok = !(filt_on && steady_cnt >= filt_limit);

	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			unit_cnt <= 10'd0;
			mult_cnt <= 2'd0;
			conv_cnt <= 16'd0;
			high_duty <= 16'h0000;
			low_duty <= 16'h0000;
			lfsr <= 16'hace1;
			steady_cnt <= 5'd0;
			comp_prev <= 1'b0;
			seq_done <= 1'b0;
			thresh_hit <= 1'b0;
			noise_seen <= 1'b0;
			charge_phase <= 1'b0;
			proximity_transmit_out <= 1'b0;
		end else if (clk_en) begin
			seq_done <= 1'b0;
			thresh_hit <= 1'b0;
			noise_seen <= 1'b0;
			// excitation follows the engine clock while enabled; it drops
			// at once on disable so pin and load gate agree
			if (!prox_cfg_enable_receive_cancel_cal[7])
				proximity_transmit_out <= 1'b0;
			else if (engine_tick)
				proximity_transmit_out <= ~proximity_transmit_out;
			if (engine_tick)
				lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			case (state)
			ST_IDLE: begin
				unit_cnt <= 10'd0;
				mult_cnt <= 2'd0;
				if (start_req) begin
					high_duty <= 16'h0000;
					low_duty <= 16'h0000;
					if (touch_ctrl_status[`BIT_AUTO_DELAY_EN])
						state <= ST_DELAY;
					else
						state <= ST_SETTLE;
				end
			end
			ST_DELAY: if (engine_tick) begin
				if (unit_cnt == `START_DELAY_UNIT - 10'd1) begin
					unit_cnt <= 10'd0;
					mult_cnt <= mult_cnt + 2'd1;
					if (mult_cnt == delay_f) begin
						mult_cnt <= 2'd0;
						state <= ST_SETTLE;
					end
				end else begin
					unit_cnt <= unit_cnt + 10'd1;
				end
			end
			ST_SETTLE: if (engine_tick) begin
				if (unit_cnt == `SETTLE_UNIT - 10'd1) begin
					unit_cnt <= 10'd0;
					mult_cnt <= mult_cnt + 2'd1;
					if (mult_cnt == settle_f) begin
						conv_cnt <= 16'd0;
						state <= ST_CONV;
					end
				end else begin
					unit_cnt <= unit_cnt + 10'd1;
				end
			end
			ST_CONV: if (engine_tick) begin
				// random skip of a phase when enabled
				if (!touch_ctrl_status[`BIT_PSEUDO_RANDOM] || !lfsr[0])
					charge_phase <= ~charge_phase;
				comp_prev <= cmp_s2;
				if (cmp_s2 == comp_prev && steady_cnt != 5'h1f)
					steady_cnt <= steady_cnt + 5'd1;
				else if (cmp_s2 != comp_prev)
					steady_cnt <= 5'd0;
				if (filt_on && steady_cnt == filt_limit)
					noise_seen <= 1'b1;
				if (comp_ok) begin
					if (cmp_s2)
						high_duty <= high_duty + 16'd1;
					else
						low_duty <= low_duty + 16'd1;
				end
				conv_cnt <= conv_cnt + 16'd1;
				if (conv_cnt == CONV_LEN[15:0] - 16'd1)
					state <= ST_DONE;
			end
			ST_DONE: begin
				seq_done <= 1'b1;
				if (auto_mode && {1'b0, low_duty} > eff_thresh)
					thresh_hit <= 1'b1;
				charge_phase <= 1'b0;
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// analog control outputs
	always @(posedge aclk) begin
		if (!aresetn) begin
			receive_cancel_cal <= 7'd0;
			pseudo_load_select <= 4'd0;
			pull_current_select <= 4'd0;
			pull_resistor_select <= 4'd0;
			charge_cap_select <= 3'd0;
			irq <= 1'b0;
		end else if (clk_en) begin
			receive_cancel_cal <= prox_cfg_enable_receive_cancel_cal[6:0];
			pseudo_load_select <= prox_cfg_enable_receive_cancel_cal[7] ?
				prox_cfg_load[3:0] : 4'd0;
			pull_current_select <= touch_pullup_ctrl[7] ?
				touch_pullup_ctrl[3:0] : 4'd0;
			pull_resistor_select <= touch_pullup_ctrl[6] ?
				touch_pullup_ctrl[3:0] : 4'd0;
			charge_cap_select <= touch_ctrl_status[7:5];
			irq <= |(irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write path
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire busy_now = (state != ST_IDLE);
	wire [7:0] wb = w_data[7:0];
	wire       wr_lane = w_strb[0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 18'h0_0000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			prox_cfg_enable_receive_cancel_cal <= `RST_PROX_ENABLE_RECEIVE_CANCEL_CAL;
			prox_cfg_cref_gain <= `RST_PROX_CREF_GAIN;
			prox_cfg_amp_power <= `RST_PROX_AMP_POWER;
			prox_cfg_load <= `RST_PROX_LOAD;
			touch_clock_select <= `RST_ZERO8;
			touch_ctrl_status <= `RST_ZERO8;
			engine_cfg <= `RST_ZERO8;
			touch_pullup_ctrl <= `RST_ZERO8;
			slow_baseline <= 16'h0000;
			detect_threshold <= 16'h0000;
			irq_status <= 2'b00;
			irq_mask <= 2'b00;
		end else if (clk_en) begin
			s_axi_awready <= !aw_held && !s_axi_awready;
			s_axi_wready <= !w_held && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// hardware clears start at the end of the sequence
			if (state == ST_DONE)
				touch_ctrl_status[`BIT_START_BUSY] <= 1'b0;
			// hardware set events; set beats clear below
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				if (wr_lane) case (aw_addr[17:2])
				`OFS_PROX_ENABLE_RECEIVE_CANCEL_CAL: prox_cfg_enable_receive_cancel_cal <= wb;
				`OFS_PROX_CREF_GAIN:    prox_cfg_cref_gain <= wb;
				`OFS_PROX_AMP_POWER:    prox_cfg_amp_power <= wb;
				`OFS_PROX_LOAD:         prox_cfg_load <= {4'h0, wb[3:0]};
				`OFS_CLOCK_SELECT:      touch_clock_select <= {4'h0, wb[3:0]};
				`OFS_CTRL_STATUS: begin
					touch_ctrl_status[7:3] <= wb[7:3];
					// flags only clear by writing zero
					if (!wb[`BIT_LFN_FLAG] && !noise_seen)
						touch_ctrl_status[`BIT_LFN_FLAG] <= 1'b0;
					if (!wb[`BIT_INT_FLAG] && !seq_done && !thresh_hit)
						touch_ctrl_status[`BIT_INT_FLAG] <= 1'b0;
					if (wb[`BIT_START_BUSY] && state != ST_DONE)
						touch_ctrl_status[`BIT_START_BUSY] <= 1'b1;
				end
				`OFS_BASELINE_LO:  slow_baseline[7:0] <= wb;
				`OFS_BASELINE_HI:  slow_baseline[15:8] <= wb;
				`OFS_THRESHOLD_LO: detect_threshold[7:0] <= wb;
				`OFS_THRESHOLD_HI: detect_threshold[15:8] <= wb;
				`OFS_PULLUP_CTRL:  touch_pullup_ctrl <= {wb[7:6], 2'b00, wb[3:0]};
				`OFS_ENGINE_CFG:   engine_cfg <= wb;
				`OFS_IRQ_STATUS:   irq_status <= irq_status & ~wb[1:0];
				`OFS_IRQ_MASK:     irq_mask <= wb[1:0];
				default: s_axi_bresp <= 2'b10;
				endcase
				else if (aw_addr[17:2] != `OFS_IRQ_STATUS) s_axi_bresp <= 2'b00;
			end
			if (noise_seen) begin
				touch_ctrl_status[`BIT_LFN_FLAG] <= 1'b1;
				irq_status[1] <= 1'b1;
			end
			if (seq_done || thresh_hit) begin
				touch_ctrl_status[`BIT_INT_FLAG] <= 1'b1;
				irq_status[0] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read path
	reg [7:0] rd_byte;
	reg       rd_err;
	always @* begin
		rd_byte = 8'h00;
		rd_err = 1'b0;
		case (s_axi_araddr[17:2])
		`OFS_PROX_ENABLE_RECEIVE_CANCEL_CAL: rd_byte = prox_cfg_enable_receive_cancel_cal;
		`OFS_PROX_CREF_GAIN:    rd_byte = prox_cfg_cref_gain;
		`OFS_PROX_AMP_POWER:    rd_byte = prox_cfg_amp_power;
		`OFS_PROX_LOAD:         rd_byte = prox_cfg_load;
		`OFS_CLOCK_SELECT:      rd_byte = touch_clock_select;
		`OFS_CTRL_STATUS:
			rd_byte = {touch_ctrl_status[7:1], busy_now};
		`OFS_HIGH_DUTY_LO: rd_byte = high_duty[7:0];
		`OFS_HIGH_DUTY_HI: rd_byte = high_duty[15:8];
		`OFS_LOW_DUTY_LO:  rd_byte = low_duty[7:0];
		`OFS_LOW_DUTY_HI:  rd_byte = low_duty[15:8];
		`OFS_BASELINE_LO:  rd_byte = slow_baseline[7:0];
		`OFS_BASELINE_HI:  rd_byte = slow_baseline[15:8];
		`OFS_THRESHOLD_LO: rd_byte = detect_threshold[7:0];
		`OFS_THRESHOLD_HI: rd_byte = detect_threshold[15:8];
		`OFS_PULLUP_CTRL:  rd_byte = touch_pullup_ctrl;
		`OFS_ENGINE_CFG:   rd_byte = engine_cfg;
		`OFS_IRQ_STATUS:   rd_byte = {6'd0, irq_status};
		`OFS_IRQ_MASK:     rd_byte = {6'd0, irq_mask};
		default:           rd_err = 1'b1;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (clk_en) begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_byte};
				s_axi_rresp <= rd_err ? 2'b10 : 2'b00;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // touch_key_proximity_ctrl
`default_nettype wire

// ==== rtl/touch_key_consts.vh ====
`ifndef TOUCH_KEY_CONSTS_VH
`define TOUCH_KEY_CONSTS_VH
// register indices; the bus byte address is four times the index
`define OFS_PROX_ENABLE_RECEIVE_CANCEL_CAL 16'ha008
`define OFS_PROX_CREF_GAIN    16'ha009
`define OFS_PROX_AMP_POWER    16'ha00a
`define OFS_PROX_LOAD         16'ha00b
`define OFS_CLOCK_SELECT      16'ha00c
`define OFS_CTRL_STATUS       16'ha01b
`define OFS_HIGH_DUTY_LO      16'ha01c
`define OFS_HIGH_DUTY_HI      16'ha01d
`define OFS_LOW_DUTY_LO       16'ha01e
`define OFS_LOW_DUTY_HI       16'ha01f
`define OFS_BASELINE_LO       16'ha028
`define OFS_BASELINE_HI       16'ha029
`define OFS_THRESHOLD_LO      16'ha02a
`define OFS_THRESHOLD_HI      16'ha02b
`define OFS_PULLUP_CTRL       16'ha02c
`define OFS_ENGINE_CFG        16'ha030
`define OFS_IRQ_STATUS        16'ha034
`define OFS_IRQ_MASK          16'ha038
// reset values
`define RST_PROX_ENABLE_RECEIVE_CANCEL_CAL 8'h00
`define RST_PROX_CREF_GAIN    8'h78
`define RST_PROX_AMP_POWER    8'h27
`define RST_PROX_LOAD         8'h07
`define RST_ZERO8             8'h00
// control/status bit positions; proximity enable is bit 7 of prox_cfg_enable_receive_cancel_cal
`define BIT_START_BUSY        0
`define BIT_INT_FLAG          1
`define BIT_LFN_FLAG          2
`define BIT_PSEUDO_RANDOM     3
`define BIT_AUTO_DELAY_EN     4
`define BIT_PROX_ENABLE       7
// engine config fields (own register)
`define BIT_AUTO_MODE         0
`define BIT_THRESH_MODE       1
`define POS_SETTLE            2
`define POS_START_DELAY       4
`define POS_NOISE_FILT        6
// timing in engine-clock periods
`define SETTLE_UNIT           10'd4
`define START_DELAY_UNIT      10'd256
`define NOISE_UNIT            5'd8
`define CONV_CYCLES           16'd1024
`endif

// ==== verification/touch_key_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module touch_key_sva #(
	parameter CONV_LEN = 1024
) (
	// clock and run control
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        clk_en,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// engine outputs
	input wire logic        charge_phase,
	input wire logic        proximity_transmit_out,
	input wire logic [3:0]  pseudo_load_select,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// answers hold until the master takes them
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
	// answer timing after the handshake
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == 2'b10
		|-> s_axi_rdata == 32'h0000_0000) else $error("error read with data");
	// engine frozen while the run enable is low
	chk_engine_freeze: assert property (!clk_en |=> $stable(charge_phase)
		&& $stable(proximity_transmit_out)) else $error("engine moved when frozen");
	// reset clears the engine side
	chk_reset_quiet: assert property (disable iff (1'b0)
		!aresetn && clk_en |=> !irq && !charge_phase && !proximity_transmit_out
		&& pseudo_load_select == 4'h0) else $error("output live in reset");
	// cycles the excitation has stood still while the engine runs
	logic       tx_last;
	logic [9:0] tx_still;
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_last <= 1'b0;
			tx_still <= 10'h000;
		end else if (clk_en) begin
			tx_last <= proximity_transmit_out;
			if (proximity_transmit_out != tx_last)
				tx_still <= 10'h000;
			else if (tx_still != 10'h3ff)
				tx_still <= tx_still + 10'h001;
		end
	end
	chk_load_idle: assert property (tx_still == 10'h3ff
		|-> pseudo_load_select == 4'h0) else $error("load on without proximity");
endmodule // touch_key_sva
bind touch_key_proximity_ctrl touch_key_sva #(.CONV_LEN(CONV_LEN)) i_sva (
	.aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.charge_phase, .proximity_transmit_out, .pseudo_load_select, .irq);
`default_nettype wire

// ==== verification/afe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module afe_model (
	// engine side
	input wire logic charge_phase,
	input wire logic stuck_level,
	// analog returns
	output logic     comparator_in,
	output logic     slow_high_oscillator
);
	// free running slow oscillator, phase unrelated to the system clock
	initial slow_high_oscillator = 1'b0;
	always #157 slow_high_oscillator = ~slow_high_oscillator;
	// comparator is the inverse of charge phase; stuck models low-frequency noise
	// shield stays off, the receive path alone drives the comparator
	always @* comparator_in = stuck_level | ~charge_phase;
endmodule // afe_model
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	// bench drive
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        clk_en = 1'b1;
	logic [17:0] awaddr = 18'h0_0000;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [17:0] araddr = 18'h0_0000;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        stuck = 1'b0;
	logic [1:0]  last_resp;
	int          num_errors = 0;
	int          n_tests = 0;
	// design outputs
	wire logic        awready, wready, bvalid, arready, rvalid, irq;
	wire logic        comp, sosc, charge_phase, tx;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [6:0]  rx_cal;
	wire logic [3:0]  load_sel, pull_cur, pull_res;
	wire logic [2:0]  cap_sel;

	always #10 aclk = ~aclk;

	touch_key_proximity_ctrl #(.CONV_LEN(32)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_in(comp),
		.slow_high_oscillator(sosc), .charge_phase(charge_phase),
		.proximity_transmit_out(tx), .receive_cancel_cal(rx_cal),
		.pseudo_load_select(load_sel), .pull_current_select(pull_cur),
		.pull_resistor_select(pull_res), .charge_cap_select(cap_sel), .irq(irq));

	afe_model i_afe (.charge_phase(charge_phase), .stuck_level(stuck),
		.comparator_in(comp), .slow_high_oscillator(sosc));

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic timeout;
		num_errors++;
		$display("[FAIL] %0t wait ran out", $time);
		give_verdict();
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one write, address and data offered together
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		int n;
		awaddr <= {a, 2'b00};
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		last_resp = bresp;
		@(posedge aclk);
		if (n == 200) timeout();
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		int n;
		araddr <= {a, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		d = rdata[7:0];
		last_resp = rresp;
		@(posedge aclk);
		if (n == 200) timeout();
	endtask

	// polls busy until clear, returns elapsed cycles
	task automatic wait_idle(output int cyc);
		logic [7:0] s;
		time t0;
		int n;
		t0 = $time;
		for (n = 0; n < 600; n++) begin
			rd(16'ha01b, s);
			if (s[0] === 1'b0) break;
		end
		if (n == 600) timeout();
		cyc = int'(($time - t0) / 20);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values;
		logic [15:0] a [13] = '{16'ha008, 16'ha009, 16'ha00a, 16'ha00b,
			16'ha00c, 16'ha01b, 16'ha01c, 16'ha01d, 16'ha01e, 16'ha01f,
			16'ha028, 16'ha02b, 16'ha02c};
		logic [7:0] v [13] = '{8'h00, 8'h78, 8'h27, 8'h07, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [7:0] d;
		for (int i = 0; i < 13; i++) begin
			rd(a[i], d);
			check(d, v[i]);
		end
		wr(16'ha01c, 8'hff);
		rd(16'ha01c, d);
		check(d, 8'h00);
		wr(16'ha029, 8'h5a);
		rd(16'ha029, d);
		check(d, 8'h5a);
		rd(16'ha040, d);
		check({last_resp, d}, 10'h200);
		wr(16'ha040, 8'h11);
		check(last_resp, 2'b10);
	endtask

	task automatic t_front_end;
		int div [7] = '{2, 4, 6, 10, 16, 32, 256};
		logic last;
		int gap;
		wr(16'ha008, 8'h85);
		repeat (3) @(posedge aclk);
		check(rx_cal, 7'h05);
		check(load_sel, 4'h7);
		for (int s = 0; s < 7; s++) begin
			wr(16'ha00c, 8'(s));
			for (int k = 0; k < 3; k++) begin
				last = tx;
				for (gap = 0; gap < 600 && tx === last; gap++) @(posedge aclk);
			end
			if (gap == 600) timeout();
			check(gap, div[s]);
		end
		wr(16'ha008, 8'h05);
		repeat (3) @(posedge aclk);
		check({load_sel, tx}, 5'h00);
		wr(16'ha02c, 8'h8a);
		repeat (3) @(posedge aclk);
		check({pull_cur, pull_res}, 8'ha0);
		wr(16'ha02c, 8'h45);
		repeat (3) @(posedge aclk);
		check({pull_cur, pull_res}, 8'h05);
	endtask

	task automatic t_convert;
		logic [7:0] d, h0, h1, l0, l1;
		int c;
		wr(16'ha00c, 8'h00);
		wr(16'ha038, 8'h01);
		wr(16'ha01b, 8'he1);
		rd(16'ha01b, d);
		check({cap_sel, d[0]}, 4'hf);
		clk_en <= 1'b0;
		repeat (3) @(posedge aclk);
		clk_en <= 1'b1;
		wait_idle(c);
		rd(16'ha01b, d);
		check(d[1:0], 2'b10);
		rd(16'ha01c, h0);
		rd(16'ha01d, h1);
		rd(16'ha01e, l0);
		rd(16'ha01f, l1);
		check({h1, h0} + {l1, l0}, 32'd32);
		repeat (2) @(posedge aclk);
		check(irq, 1'b1);
		wr(16'ha038, 8'h00);
		repeat (2) @(posedge aclk);
		check(irq, 1'b0);
		wr(16'ha038, 8'h01);
		repeat (2) @(posedge aclk);
		check(irq, 1'b1);
		wr(16'ha034, 8'h01);
		repeat (2) @(posedge aclk);
		rd(16'ha034, d);
		check({irq, d[0]}, 2'b00);
	endtask

	task automatic t_noise;
		logic [7:0] d;
		int c;
		wr(16'ha030, 8'h40);
		stuck <= 1'b1;
		wr(16'ha01b, 8'h09);
		wait_idle(c);
		rd(16'ha01b, d);
		check(d[2], 1'b1);
		rd(16'ha034, d);
		check(d[1], 1'b1);
		wr(16'ha01b, 8'h00);
		rd(16'ha01b, d);
		check(d[2], 1'b0);
		wr(16'ha030, 8'h00);
		wr(16'ha01b, 8'h01);
		wait_idle(c);
		rd(16'ha01b, d);
		check(d[2], 1'b0);
		stuck <= 1'b0;
	endtask

	task automatic t_start_delay;
		int c;
		wr(16'ha01b, 8'h01);
		wait_idle(c);
		check(c < 512, 1'b1);
		wr(16'ha01b, 8'h11);
		wait_idle(c);
		check(c >= 512, 1'b1);
		wr(16'ha030, 8'h10);
		wr(16'ha01b, 8'h11);
		wait_idle(c);
		check(c >= 1024, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		t_reset_values();
		t_front_end();
		t_convert();
		t_noise();
		t_start_delay();
		give_verdict();
	end
endmodule // tb
`default_nettype wire
